// *** design/cssq_pkg.sv ***
/*
  Shared constants for the converter startup sequencer: register map,
  field positions, reset values, cycle counts, state encodings and helpers.
  Assumes a 250 MHz bus clock; all counts derive from that period.
*/
package cssq_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_MODE   = 8'h04;
  localparam logic [7:0] A_SYNTH  = 8'h08;
  localparam logic [7:0] A_CALCFG = 8'h0C;
  localparam logic [7:0] A_XCVR   = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_RATE   = 8'h18;

  // ==========================================================
  // Control register bits
  localparam int B_SOFT_RST  = 0;
  localparam int B_SYNTH_RST = 1;
  localparam int B_OSC_CAL   = 2;
  localparam int B_LINK_EN   = 3;
  localparam int B_CAL_EN    = 4;
  localparam int B_SW_TRIG   = 5;
  localparam int B_PIN_TRIG  = 6;
  localparam int B_OVERRANGE_ENABLE    = 7;
  localparam int B_SYNC_SEL  = 8;
  localparam int B_STAT_SEL  = 9;
  localparam int CTRL_W      = 10;
  localparam logic [9:0] CTRL_RST = 10'h006;

  // ==========================================================
  // Mode register: link mode [4:0], frame count minus one [12:8]
  localparam int F_MODE_LSB = 0;
  localparam int F_KM1_LSB  = 8;
  localparam int MODE_W     = 5;
  localparam logic [4:0] MODE_RST       = 5'h00;
  localparam logic [4:0] KM1_RST        = 5'h00;
  localparam logic [4:0] MODE_64B_FIRST = 5'h08;
  localparam logic [4:0] MODE_EIGHT     = 5'h08;
  localparam logic [7:0] RATIO_X8_MODE8 = 8'h63;

  // ==========================================================
  // Synth register: bias [7:0], trim [15:8], P [17:16], V [21:18], N [29:22]
  localparam int SYNTH_W = 30;
  localparam logic [29:0] SYNTH_RST = 30'h0000_0000;

  // ==========================================================
  // Calibration config: config a [7:0] (bit 0 = foreground), config b [15:8]
  localparam int B_FG_MODE = 0;
  localparam int CALCFG_W  = 16;
  localparam logic [15:0] CALCFG_RST = 16'h0001;

  // ==========================================================
  // Transceiver refclk control: enable bit 7, divider code [2:0]
  localparam int B_XC_EN     = 7;
  localparam int XC_CODE_W   = 3;
  localparam int XC_HALF_OFS = 3;
  localparam logic [7:0] XCVR_RST = 8'h00;

  // ==========================================================
  // Status bits
  localparam int S_INIT     = 0;
  localparam int S_OSC_DONE = 1;
  localparam int S_LOCKED   = 2;
  localparam int S_FOREGROUND_DONE_BIT  = 3;
  localparam int S_CAL_BUSY = 4;
  localparam int S_LK_DATA  = 5;
  localparam int S_LK_CGS   = 6;
  localparam int S_VALID    = 7;
  localparam int S_STRAP_SY = 8;
  localparam int S_STRAP_RF = 9;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int INIT_TIME_NS    = 1000;
  localparam int OSC_CAL_TIME_NS = 2000;
  localparam int LOCK_TIME_NS    = 1000;
  localparam int FG_CAL_TIME_NS  = 4000;
  localparam int INIT_CYCLES     = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OSC_CAL_CYCLES  = (OSC_CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_CYCLES     = (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FG_CAL_CYCLES   = (FG_CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W           = 16;

  // ==========================================================
  // State encodings
  typedef enum logic [1:0] {
    SY_OFF   = 2'h0,
    SY_CAL   = 2'h1,
    SY_LOCK  = 2'h2,
    SY_READY = 2'h3
  } cssq_synth_e;

  typedef enum logic [1:0] {
    LK_IDLE = 2'h0,
    LK_CGS  = 2'h1,
    LK_DATA = 2'h2
  } cssq_link_e;

  // ==========================================================
  // Helpers
  function automatic logic is_8b10b(input logic [4:0] m);
    return m < MODE_64B_FIRST;
  endfunction : is_8b10b

  // Line rate over sample rate, times eight; zero where unknown
  function automatic logic [7:0] ratio_x8(input logic [4:0] m);
    return (m == MODE_EIGHT) ? RATIO_X8_MODE8 : 8'h00;
  endfunction : ratio_x8

endpackage : cssq_pkg

// *** design/cssq_refclk_div.sv ***
/*
  Transceiver reference clock divider: toggles its output every half
  period of the selected ratio. Assumes hclk stands in for the lane
  clock and that the owner holds enable low while changing the code.
*/
`timescale 1ns/1ps
module cssq_refclk_div
  import cssq_pkg::*;
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  clk_en,
  // Control
  input  wire logic                  enable,
  input  wire logic [XC_CODE_W-1:0]  div_code,
  // Output
  output logic                       clk_out
);

  logic [10:0] half;
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic        out_d;

  // ==========================================================
  // Ratio is sixteen shifted by code; code 1 gives 32
  always_comb
  begin
    half  = 11'(11'h001 << (4'(div_code) + 4'(XC_HALF_OFS))); // Four bits: code 7 shifts by 10
    cnt_d = cnt_q;
    out_d = clk_out;
    if (!enable)
    begin
      cnt_d = 11'h000;
      out_d = 1'b0;
    end
    else if (cnt_q >= half - 11'h001)
    begin
      cnt_d = 11'h000;
      out_d = !clk_out; // RULE12
    end
    else
      cnt_d = cnt_q + 11'h001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q   <= 11'h000;
      clk_out <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q   <= cnt_d;
      clk_out <= out_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_div_toggle: assert property (clk_en && enable && cnt_q == half - 11'h001 ##1 enable // RULE12
    |-> clk_out != $past(clk_out))
    else $error("refclk did not toggle at half period");
  chk_div_hold: assert property (clk_en && enable && cnt_q < half - 11'h001 // RULE12
    |=> $stable(clk_out))
    else $error("refclk toggled early");

endmodule : cssq_refclk_div

// *** design/cssq_startup.sv ***
/*
  Converter startup sequencer: AHB-Lite register slave, strap capture,
  init timer, synthesizer calibration and lock, link and foreground
  calibration state machines, data-valid and status outputs.
  Assumes one bus master, hready looped from hreadyout, async pins.
*/
// Design decisions made here: the register addresses and register access over AHB-Lite.
// Overview of operation
// (RULE1) Board straps synth enable and reference select before power-up.
// (RULE2) Host keeps power-down low while repeat or aux clocks are needed.
// (RULE3) Host soft-resets, then polls init-done until it reads one.
// (RULE4) Host sets synth reset, writes bias 0x4A, programs P, V, N.
// (RULE5) Host enables oscillator calibration, or disables it and writes trim.
// (RULE6) Clearing synth reset starts oscillator calibration and enables synth.
// (RULE7) Host clears link enable before changing link settings.
// (RULE8) Host clears calibration enable before changing calibration settings.
// (RULE9) Host writes link mode, then frame count minus one for 8B/10B.
// (RULE10) Host picks single sync input or differential timestamp input.
// (RULE11) Host configures foreground or background calibration before enabling.
// (RULE12) Refclk output runs at line rate over divider; 0x81 means 32.
// (RULE13) Host confirms osc-cal-done and synth-locked before enabling calibration.
// (RULE14) Host sets calibration enable to restart calibration machine.
// (RULE15) Host then sets link enable to restart link machine.
// (RULE16) Host triggers calibration by soft bit 0-then-1 or pin pulse.
// (RULE17) Device raises status pin and foreground-done when calibration ends.
// (RULE18) Device follows SYNC in 8B/10B modes, ignores it in 64B/66B.
// (RULE19) Data valid only when link is up and calibration done.
// (RULE20) Line rate equals sample rate times mode ratio, 12.375 in mode 8.
// (RULE21) System makes SYSREF at line rate over 66*32*E*n.
// (RULE22) Receiver core clock is an integer multiple of reference clock.
`timescale 1ns/1ps
module cssq_startup
  import cssq_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pins from outside
  input  wire logic        synth_enable_strap,
  input  wire logic        ref_input_select_strap,
  input  wire logic        power_down_pin,
  input  wire logic        sync_single_input,
  input  wire logic        timestamp_diff_input_p,
  input  wire logic        timestamp_diff_input_n,
  input  wire logic        calib_trigger_pin,
  // Pins to outside
  output logic             calib_status_pin,
  output logic             xcvr_refclk_output,
  output logic             link_cgs_active,
  output logic             data_valid,
  output logic             aux_clock_enable,
  output logic             overrange_enable
);

  localparam int INIT_N = INIT_CYCLES;
  localparam int FG_N   = FG_CAL_CYCLES;

  // ==========================================================
  // Pin synchronisers: meta stage feeds only the second stage
  logic [6:0] pin_meta_q;
  logic [6:0] pin_q;
  logic       trig_prev_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Trigger pin idles high; a low reset would fake a rising edge
      pin_meta_q  <= 7'h01;
      pin_q       <= 7'h01;
      trig_prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_meta_q  <= {synth_enable_strap, ref_input_select_strap, power_down_pin,
                      sync_single_input, timestamp_diff_input_p,
                      timestamp_diff_input_n, calib_trigger_pin};
      pin_q       <= pin_meta_q;
      trig_prev_q <= pin_q[0];
    end
  end

  // ==========================================================
  // Bus slave: zero wait states, reads sampled in the address phase
  logic                dp_we_q;
  logic [7:0]          dp_addr_q;
  logic                taken;
  logic                we;
  logic                mapped;
  logic [31:0]         rdata_d;
  logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic [MODE_W-1:0]   mode_q, mode_d;
  logic [MODE_W-1:0]   km1_q, km1_d;
  logic [SYNTH_W-1:0]  synth_q, synth_d;
  logic [CALCFG_W-1:0] calcfg_q, calcfg_d;
  logic [7:0]          xctl_q, xctl_d;
  logic                srst_q, srst_d;
  logic [31:0]         status;

  assign taken  = hsel && htrans[1] && hready;
  assign we     = dp_we_q && clk_en;
  assign mapped = (haddr[31:8] == 24'h00_0000);

  // Register writes; soft reset returns every register to its reset value
  always_comb
  begin
    ctrl_d   = ctrl_q;
    mode_d   = mode_q;
    km1_d    = km1_q;
    synth_d  = synth_q;
    calcfg_d = calcfg_q;
    xctl_d   = xctl_q;
    srst_d   = 1'b0;
    if (srst_q)
    begin
      ctrl_d   = CTRL_RST;
      mode_d   = MODE_RST;
      km1_d    = KM1_RST;
      synth_d  = SYNTH_RST;
      calcfg_d = CALCFG_RST;
      xctl_d   = XCVR_RST;
    end
    else if (we)
    begin
      case (dp_addr_q)
        A_CTRL:
        begin
          ctrl_d             = hwdata[CTRL_W-1:0];
          ctrl_d[B_SOFT_RST] = 1'b0;
          srst_d             = hwdata[B_SOFT_RST];
        end
        A_MODE:
        begin
          mode_d = hwdata[F_MODE_LSB +: MODE_W];
          km1_d  = hwdata[F_KM1_LSB +: MODE_W];
        end
        A_SYNTH:  synth_d  = hwdata[SYNTH_W-1:0];
        A_CALCFG: calcfg_d = hwdata[CALCFG_W-1:0];
        A_XCVR:   xctl_d   = hwdata[7:0];
        default:  ; // Read-only or unmapped: write dropped
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero with an OKAY answer
  always_comb
  begin
    rdata_d = hrdata;
    if (taken && !hwrite)
    begin
      rdata_d = 32'h0000_0000;
      if (mapped)
      begin
        case (haddr[7:0])
          A_CTRL:   rdata_d = {22'h00_0000, ctrl_q};
          A_MODE:   rdata_d = {19'h0_0000, km1_q, 3'h0, mode_q};
          A_SYNTH:  rdata_d = {2'h0, synth_q};
          A_CALCFG: rdata_d = {16'h0000, calcfg_q};
          A_XCVR:   rdata_d = {24'h00_0000, xctl_q};
          A_STATUS: rdata_d = status;
          A_RATE:   rdata_d = {24'h00_0000, ratio_x8(mode_q)}; // RULE20
          default:  rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_we_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      ctrl_q    <= CTRL_RST;
      mode_q    <= MODE_RST;
      km1_q     <= KM1_RST;
      synth_q   <= SYNTH_RST;
      calcfg_q  <= CALCFG_RST;
      xctl_q    <= XCVR_RST;
      srst_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      dp_we_q   <= taken && hwrite && mapped;
      dp_addr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= rdata_d;
      ctrl_q    <= ctrl_d;
      mode_q    <= mode_d;
      km1_q     <= km1_d;
      synth_q   <= synth_d;
      calcfg_q  <= calcfg_d;
      xctl_q    <= xctl_d;
      srst_q    <= srst_d;
    end
  end

  // ==========================================================
  // Straps taken once after reset release, init timer, synthesizer
  logic             strap_taken_q, strap_sy_q, strap_rf_q;
  logic [CNT_W-1:0] init_cnt_q, init_cnt_d;
  logic             init_done_q, init_done_d;
  cssq_synth_e      sy_q, sy_d;
  logic [CNT_W-1:0] sy_cnt_q, sy_cnt_d;
  logic             synth_start;

  // Only a real one-to-zero write of synth reset starts calibration
  assign synth_start = ctrl_q[B_SYNTH_RST] && !ctrl_d[B_SYNTH_RST] && strap_sy_q;

  always_comb
  begin
    init_cnt_d  = init_cnt_q;
    init_done_d = init_done_q;
    sy_d        = sy_q;
    sy_cnt_d    = sy_cnt_q;
    if (!init_done_q)
    begin
      if (init_cnt_q == CNT_W'(INIT_N - 1))
        init_done_d = 1'b1;
      else
        init_cnt_d = init_cnt_q + 16'h0001;
    end
    case (sy_q)
      SY_OFF:
        if (synth_start) // RULE6
        begin
          sy_d     = SY_CAL;
          sy_cnt_d = ctrl_q[B_OSC_CAL] ? CNT_W'(OSC_CAL_CYCLES) : 16'h0001;
        end
      SY_CAL:
        if (sy_cnt_q == 16'h0001)
        begin
          sy_d     = SY_LOCK;
          sy_cnt_d = CNT_W'(LOCK_CYCLES);
        end
        else
          sy_cnt_d = sy_cnt_q - 16'h0001;
      SY_LOCK:
        if (sy_cnt_q == 16'h0001)
          sy_d = SY_READY; // RULE6
        else
          sy_cnt_d = sy_cnt_q - 16'h0001;
      SY_READY: ;
      default: sy_d = SY_OFF;
    endcase
    if (ctrl_d[B_SYNTH_RST] || !strap_sy_q)
      sy_d = SY_OFF;
    if (srst_q)
    begin
      init_cnt_d  = 16'h0000;
      init_done_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_taken_q <= 1'b0;
      strap_sy_q    <= 1'b0;
      strap_rf_q    <= 1'b0;
      init_cnt_q    <= 16'h0000;
      init_done_q   <= 1'b0;
      sy_q          <= SY_OFF;
      sy_cnt_q      <= 16'h0000;
    end
    else if (clk_en)
    begin
      // Straps are latched once the synchronisers have filled
      if (!strap_taken_q && init_cnt_q == 16'h0002)
      begin
        strap_taken_q <= 1'b1;
        strap_sy_q    <= pin_q[6];
        strap_rf_q    <= pin_q[5];
      end
      init_cnt_q  <= init_cnt_d;
      init_done_q <= init_done_d;
      sy_q        <= sy_d;
      sy_cnt_q    <= sy_cnt_d;
    end
  end

  // ==========================================================
  // Link and foreground calibration machines, pin outputs
  cssq_link_e       lk_q, lk_d;
  logic             sync_req;
  logic             busy_q, busy_d;
  logic [CNT_W-1:0] cal_cnt_q, cal_cnt_d;
  logic             foreground_done_bit_q, foreground_done_bit_d;
  logic             cal_start;
  logic             trig_sw, trig_pin;

  // Sync is active low; source picked by the select bit
  assign sync_req  = !(ctrl_q[B_SYNC_SEL] ? (pin_q[2] && !pin_q[1]) : pin_q[3]);
  assign trig_sw   = !ctrl_q[B_SW_TRIG] && ctrl_d[B_SW_TRIG];
  assign trig_pin  = ctrl_q[B_PIN_TRIG] && !trig_prev_q && pin_q[0];
  // Background mode ignores triggers, and the engine never starts in that mode
  assign cal_start = ctrl_q[B_CAL_EN] && calcfg_q[B_FG_MODE] && !busy_q
                     && (trig_sw || trig_pin);

  always_comb
  begin
    lk_d      = lk_q;
    busy_d    = busy_q;
    cal_cnt_d = cal_cnt_q;
    foreground_done_bit_d = foreground_done_bit_q;
    case (lk_q)
      LK_IDLE:
        if (is_8b10b(mode_q) && sync_req) // RULE18
          lk_d = LK_CGS;
        else
          lk_d = LK_DATA;
      LK_CGS:
        if (!sync_req || !is_8b10b(mode_q))
          lk_d = LK_DATA;
      LK_DATA:
        if (is_8b10b(mode_q) && sync_req) // RULE18
          lk_d = LK_CGS;
      default: lk_d = LK_IDLE;
    endcase
    if (!ctrl_q[B_LINK_EN])
      lk_d = LK_IDLE;
    if (cal_start)
    begin
      busy_d    = 1'b1;
      foreground_done_bit_d = 1'b0;
      cal_cnt_d = CNT_W'(FG_N);
    end
    else if (busy_q)
    begin
      if (cal_cnt_q == 16'h0001)
      begin
        busy_d    = 1'b0;
        foreground_done_bit_d = 1'b1; // RULE17
      end
      cal_cnt_d = cal_cnt_q - 16'h0001;
    end
    if (!ctrl_q[B_CAL_EN])
      busy_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lk_q             <= LK_IDLE;
      busy_q           <= 1'b0;
      cal_cnt_q        <= 16'h0000;
      foreground_done_bit_q        <= 1'b0;
      calib_status_pin <= 1'b0;
      link_cgs_active  <= 1'b0;
      data_valid       <= 1'b0;
      aux_clock_enable <= 1'b0;
      overrange_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      lk_q             <= lk_d;
      busy_q           <= busy_d;
      cal_cnt_q        <= cal_cnt_d;
      foreground_done_bit_q        <= foreground_done_bit_d;
      calib_status_pin <= ctrl_q[B_STAT_SEL] ? busy_q : foreground_done_bit_q; // RULE17
      link_cgs_active  <= (lk_q == LK_CGS);
      data_valid       <= (lk_q == LK_DATA) && foreground_done_bit_q; // RULE19
      aux_clock_enable <= !pin_q[4];
      overrange_enable <= ctrl_q[B_OVERRANGE_ENABLE];
    end
  end

  assign status = {22'h00_0000, strap_rf_q, strap_sy_q, data_valid, lk_q == LK_CGS,
                   lk_q == LK_DATA, busy_q, foreground_done_bit_q, sy_q == SY_READY,
                   sy_q == SY_LOCK || sy_q == SY_READY, init_done_q};

  // Refclk for the receiver transceiver
  cssq_refclk_div u_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .enable   (xctl_q[B_XC_EN]),
    .div_code (xctl_q[XC_CODE_W-1:0]),
    .clk_out  (xcvr_refclk_output)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_synth_start: assert property (clk_en && synth_start && !srst_q |=> sy_q == SY_CAL) // RULE6
    else $error("synth calibration did not start");
  chk_synth_ready: assert property (clk_en && sy_q == SY_LOCK && sy_cnt_q == 16'h0001 // RULE6
    && !ctrl_d[B_SYNTH_RST] |=> sy_q == SY_READY)
    else $error("synth did not lock");
  chk_foreground_done_bit_set: assert property (clk_en && busy_q && cal_cnt_q == 16'h0001 && !cal_start // RULE17
    && ctrl_q[B_CAL_EN] |=> foreground_done_bit_q && !busy_q)
    else $error("foreground done not set");
  chk_fg_run_len: assert property ($rose(busy_q) |-> busy_q [*8] or !ctrl_q[B_CAL_EN]) // RULE17
    else $error("calibration ended too soon");
  chk_sync_ignored: assert property (clk_en && lk_q == LK_DATA && !is_8b10b(mode_q) // RULE18
    && ctrl_q[B_LINK_EN] |=> lk_q == LK_DATA)
    else $error("sync acted in 64B/66B mode");
  chk_sync_follow: assert property (clk_en && lk_q == LK_DATA && is_8b10b(mode_q) // RULE18
    && sync_req && ctrl_q[B_LINK_EN] |=> lk_q == LK_CGS)
    else $error("sync request ignored in 8B/10B mode");
  chk_valid_cause: assert property ($past(clk_en) |-> data_valid == // RULE19
    ($past(lk_q == LK_DATA) && $past(foreground_done_bit_q)))
    else $error("data valid without link and calibration");
  chk_rate_read: assert property (clk_en && taken && !hwrite && mapped // RULE20
    && haddr[7:0] == A_RATE |=> hrdata[7:0] == ratio_x8($past(mode_q)))
    else $error("rate readback wrong");
  chk_bus_okay: assert property (hresetn && clk_en |=> hreadyout && !hresp)
    else $error("slave stalled or errored");

  cov_link_data: cover property (lk_q == LK_CGS ##1 lk_q == LK_DATA);
  cov_foreground_done_bit: cover property ($rose(foreground_done_bit_q));
  cov_synth_ready: cover property ($rose(sy_q == SY_READY));
  cov_valid: cover property ($rose(data_valid));

endmodule : cssq_startup

// *** tb/cssq_rx_model.sv ***
/*
  Receiver model for the serial link: requests sync (active low) after
  reset or on resync, and releases it once CGS has been seen for 4 cycles.
  Assumes the device reports CGS on link_cgs_active, on the bus clock.
*/
`timescale 1ns/1ps
module cssq_rx_model
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Device link state and bench request
  input  wire logic link_cgs_active,
  input  wire logic resync,
  // Sync request to device
  output logic      sync_n
);
  logic [2:0] cnt_q;
  // ==========================================================
  // Sync request; held low until code groups are seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_n <= 1'b0;
      cnt_q  <= 3'h0;
    end
    else if (resync)
    begin
      sync_n <= 1'b0;
      cnt_q  <= 3'h0;
    end
    else if (link_cgs_active && !sync_n)
    begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h3) sync_n <= 1'b1;
    end
  end
endmodule : cssq_rx_model

// *** tb/tb.sv ***
/*
  Bench for the startup sequencer: AHB-Lite host tasks and ordered steps.
  Assumes the receiver model answers sync and hready loops from hreadyout.
*/
`timescale 1ns/1ps
module tb;
  import cssq_pkg::*;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, resync, sync_n, pd, trig, p;
  logic        cstat, rclk, cgs, dv, aux, ovr;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          error_cnt = 0, n_tests = 0, cyc = 0, k, r;
  // ==========================================================
  // Clock, timeout
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin error_cnt++; wrap_up(); end
  end
  // ==========================================================
  // Device and receiver
  cssq_startup u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .synth_enable_strap(1'b1), .ref_input_select_strap(1'b1), .power_down_pin(pd),
    .sync_single_input(sync_n), .timestamp_diff_input_p(sync_n),
    .timestamp_diff_input_n(~sync_n), .calib_trigger_pin(trig),
    .calib_status_pin(cstat), .xcvr_refclk_output(rclk), .link_cgs_active(cgs),
    .data_valid(dv), .aux_clock_enable(aux), .overrange_enable(ovr));
  cssq_rx_model u_rx (.hclk(hclk), .hresetn(hresetn), .link_cgs_active(cgs),
    .resync(resync), .sync_n(sync_n));
  // ==========================================================
  // Tasks; one helper per bus cycle keeps scenarios short
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'b10; haddr <= {24'h00_0000, a}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : rchk
  // Status is re-read until masked bits match, bounded by lim reads
  task poll(input logic [31:0] m, input logic [31:0] v, input int lim);
    for (int i = 0; i < lim; i++) begin xfer(1'b0, A_STATUS, 32'h0, rd); if ((rd & m) === v) break; end
    chk(rd & m, v);
  endtask : poll
  task wait_pin(input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge hclk); #1;
      s = (sel == 0) ? cgs : (sel == 1) ? dv : cstat;
      if (s === v) break;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask : wait_pin
  task wrap_up;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Startup sequence in documented order
  initial
  begin
    hresetn = 1'b0; pd = 1'b0; trig = 1'b1; resync = 1'b0;
    htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(A_CTRL, 32'h0000_0006);
    rchk(A_CALCFG, 32'h0000_0001);
    xfer(1'b1, A_CTRL, 32'h0000_0001, rd);
    poll(32'h0000_0301, 32'h0000_0301, 200);
    chk(aux, 1'b1);
    xfer(1'b1, A_SYNTH, 32'h0416_004A, rd);
    rchk(A_SYNTH, 32'h0416_004A);
    xfer(1'b1, A_CTRL, 32'h0000_0004, rd);
    poll(32'h0000_0006, 32'h0000_0006, 400);
    xfer(1'b1, A_MODE, 32'h0000_0008, rd);
    xfer(1'b1, A_RATE, 32'h0000_0000, rd);
    rchk(A_RATE, 32'h0000_0063);
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
    rchk(8'h40, 32'h0000_0000);
    // Refclk period in bus cycles between rising edges
    xfer(1'b1, A_XCVR, 32'h0000_0081, rd);
    p = 1'b1; r = 0; k = 0;
    repeat (100)
    begin
      @(posedge hclk); #1; k++;
      if (rclk === 1'b1 && p === 1'b0) begin if (r != 0) chk(k - r, 32); r = k; end
      p = rclk;
    end
    xfer(1'b1, A_CALCFG, 32'h0000_0001, rd);
    xfer(1'b1, A_CTRL, 32'h0000_0014, rd);
    xfer(1'b1, A_CTRL, 32'h0000_009C, rd);
    poll(32'h0000_0060, 32'h0000_0020, 10);
    chk(cgs, 1'b0);
    xfer(1'b1, A_CTRL, 32'h0000_00BC, rd);
    wait_pin(2, 1'b1, 1100);
    poll(32'h0000_0088, 32'h0000_0088, 2);
    chk({dv, ovr}, 2'b11);
    // 8B/10B mode: link waits in CGS for the receiver
    xfer(1'b1, A_CTRL, 32'h0000_00B4, rd);
    wait_pin(1, 1'b0, 5);
    xfer(1'b1, A_MODE, 32'h0000_0300, rd);
    xfer(1'b1, A_CTRL, 32'h0000_01BC, rd);
    wait_pin(0, 1'b1, 20);
    wait_pin(1, 1'b1, 40);
    @(posedge hclk) resync <= 1'b1;
    @(posedge hclk) resync <= 1'b0;
    wait_pin(1, 1'b0, 20);
    wait_pin(1, 1'b1, 40);
    // Pin-triggered foreground calibration
    xfer(1'b1, A_CTRL, 32'h0000_01FC, rd);
    @(posedge hclk) trig <= 1'b0;
    repeat (4) @(posedge hclk);
    trig <= 1'b1;
    wait_pin(2, 1'b0, 20);
    wait_pin(2, 1'b1, 1100);
    wrap_up();
  end
endmodule : tb
